// *** inc/vsl_link_if.sv ***
/*
 Serial link between controller and display driver.
 Assumes the testbench instantiates it and ties both ends to it.
*/
`timescale 1ns/1ps
interface vsl_link_if;
    logic serial_clk;
    logic serial_in;
    logic latch_strobe;
    logic blank_in;
    logic serial_out;

    modport ctrl (
        output serial_clk,
        output serial_in,
        output latch_strobe,
        output blank_in,
        input  serial_out
    );
    modport drv (
        input  serial_clk,
        input  serial_in,
        input  latch_strobe,
        input  blank_in,
        output serial_out
    );
endinterface : vsl_link_if

// *** inc/vsl_pkg.sv ***
/*
 Shared constants for the serial shift-and-latch display driver link.
 Assumes both ends are clocked by the same 250 MHz system clock.
*/
package vsl_pkg;
    localparam int WORD_BITS_W     = 20;
    localparam logic [19:0] SHIFT_RESET = 20'h00000;
    localparam logic [19:0] LATCH_RESET = 20'h00000;
    localparam int CLK_PERIOD_NS   = 4;
    // Serial clock half period, least 90 ns
    localparam int SCLK_HALF_NS    = 100;
    localparam int SCLK_HALF_CYC   = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    // Strobe high pulse, least 55 ns
    localparam int STROBE_HIGH_NS  = 60;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH      = 16;

    typedef enum logic [2:0] {
        VSL_IDLE   = 3'b000,
        VSL_LOW    = 3'b001,
        VSL_HIGH   = 3'b010,
        VSL_STRB   = 3'b011,
        VSL_STRB_L = 3'b100
    } vsl_state_type;
endpackage : vsl_pkg

// *** verification/test_vfd_serial_shift_latch.sv ***
/*
 Testbench: controller and driver joined by one link, and a second
 driver fed straight by the bench. Assumes one 250 MHz clock.
*/
`timescale 1ns/1ps
module test_vfd_serial_shift_latch import vsl_pkg::*;;
    logic                   clk = 1'b0;
    logic                   resetn = 1'b0;
    logic                   word_valid = 1'b0;
    logic [WORD_BITS_W-1:0] word_bits = 20'h00000;
    logic                   blank_req = 1'b0;
    logic                   word_ready;
    logic                   busy;
    logic [WORD_BITS_W-1:0] drive_out, latch_view, drive_b, view_b;
    int                     n_mismatch = 0;
    int                     comparisons = 0;
    logic [19:0]            exp_b = 20'h00000;
    logic [19:0]            sent_b = 20'h00000;

    vsl_link_if link ();
    vsl_link_if link_b ();
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    vsl_ctrl i_vsl_ctrl (.clk(clk), .resetn(resetn), .word_valid(word_valid),
        .word_ready(word_ready), .word_bits(word_bits),
        .blank_req(blank_req), .busy(busy), .link(link.ctrl));
    vsl_driver i_vsl_driver (.clk(clk), .resetn(resetn), .link(link.drv),
        .drive_out(drive_out), .latch_view(latch_view));
    vsl_driver i_vsl_driver_b (.clk(clk), .resetn(resetn),
        .link(link_b.drv), .drive_out(drive_b), .latch_view(view_b));
    vsl_link_assertions i_vsl_link_assertions (.clk(clk), .resetn(resetn),
        .serial_clk(link.serial_clk), .serial_in(link.serial_in),
        .latch_strobe(link.latch_strobe), .blank_in(link.blank_in),
        .serial_out(link.serial_out));

    task check(input string name, input logic [19:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task close_out;
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Ready judged where settled, request held through the taking edge
    task push(input logic [19:0] w);
        word_bits = w;
        word_valid = 1'b1;
        while (word_ready !== 1'b1)
            tick(1);
        tick(1);
        word_valid = 1'b0;
    endtask : push

    task wait_idle;
        int n;
        n = 0;
        tick(4);
        while (busy !== 1'b0 && n < 20000) begin
            tick(1);
            n++;
        end
        if (n >= 20000)
            n_mismatch++;
        tick(8);
    endtask : wait_idle

    task t_word(input logic [19:0] w);
        push(w);
        wait_idle;
        check("drive_out", drive_out, w);
        check("latch_view", latch_view, w);
    endtask : t_word

    task t_back;
        push(20'h12345);
        tick(1);
        push(20'hedcba);
        @(negedge link.latch_strobe);
        tick(8);
        check("held", latch_view, 20'h12345);
        tick(300);
        check("held_shift", latch_view, 20'h12345);
        wait_idle;
        check("second", drive_out, 20'hedcba);
    endtask : t_back

    task t_blank;
        blank_req = 1'b1;
        tick(8);
        check("blanked", drive_out, 20'h00000);
        push(20'h0f0f0);
        wait_idle;
        check("blank_out", drive_out, 20'h00000);
        check("blank_latch", latch_view, 20'h0f0f0);
        blank_req = 1'b0;
        tick(8);
        check("unblank", drive_out, 20'h0f0f0);
    endtask : t_blank

    // Fill the FIFO while the link is busy, then drain it
    task t_fill;
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            push(20'h01000 + 20'(i));
            tick(1);
        end
        check("full", {19'h0, word_ready}, 20'h00000);
        check("busy", {19'h0, busy}, 20'h00001);
        wait_idle;
        check("drained", {19'h0, word_ready}, 20'h00001);
        check("last", drive_out, 20'h01000 + 20'(FIFO_DEPTH));
    endtask : t_fill

    // Serial clock from the bench, 16 ns per phase; checks mid low phase
    task send_b(input logic b, input logic follow);
        link_b.serial_in = b;
        tick(2);
        check("view_b", view_b, exp_b);
        check("out_b", {19'h0, link_b.serial_out}, {19'h0, sent_b[19]});
        tick(2);
        link_b.serial_clk = 1'b1;
        sent_b = {sent_b[18:0], b};
        if (follow)
            exp_b = sent_b;
        tick(4);
        link_b.serial_clk = 1'b0;
    endtask : send_b

    task t_through;
        logic [20:0] pat;
        pat = 21'h1b5a93;
        link_b.latch_strobe = 1'b1;
        for (int i = 20; i >= 0; i--)
            send_b(pat[i], 1'b1);
        link_b.latch_strobe = 1'b0;
        for (int i = 0; i < 20; i++)
            send_b(1'b0, 1'b0);
        tick(6);
        check("view_b", view_b, 20'hb5a93);
        check("drive_b", drive_b, 20'hb5a93);
        check("out_b", {19'h0, link_b.serial_out}, 20'h00000);
    endtask : t_through

    initial begin
        link_b.serial_clk = 1'b0;
        link_b.serial_in = 1'b0;
        link_b.latch_strobe = 1'b0;
        link_b.blank_in = 1'b0;
        tick(20);
        resetn = 1'b1;
        tick(2);
        check("rst_out", drive_out, 20'h00000);
        check("rst_ser", {19'h00000, link.serial_out}, 20'h00000);
        t_word(20'h80001);
        t_word(20'ha5c3f);
        t_back;
        t_blank;
        t_fill;
        t_through;
        close_out;
    end

    initial begin
        tick(40000);
        n_mismatch++;
        close_out;
    end
endmodule : test_vfd_serial_shift_latch

// *** verification/vsl_link_assertions.sv ***
/*
 Checker for the serial link between controller and driver.
 Assumes the testbench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module vsl_link_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic blank_in,
    input wire logic serial_out
);
    logic [19:0] shadow_q;
    logic [7:0]  rises_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Bits seen on the wire, one place per serial clock rise
    always_ff @(posedge clk) begin
        if (!resetn)
            shadow_q <= 20'h00000;
        else if ($rose(serial_clk))
            shadow_q <= {shadow_q[18:0], serial_in};
    end

    // Rises since the last strobe fall
    always_ff @(posedge clk) begin
        if (!resetn)
            rises_q <= 8'h00;
        else if ($fell(latch_strobe))
            rises_q <= 8'h00;
        else if ($rose(serial_clk))
            rises_q <= rises_q + 8'h01;
    end

    property p_rst; $rose(resetn) |-> !serial_clk && !latch_strobe
        && !serial_out && !blank_in; endproperty
    a_rst: assert property (p_rst) else $error("link not idle at reset");
    property p_cascade; $rose(serial_clk) |-> ##6
        (serial_out == shadow_q[19]); endproperty
    a_cascade: assert property (p_cascade) else $error("cascade bit");
    property p_out_edge; $changed(serial_out) |-> serial_clk; endproperty
    a_out_edge: assert property (p_out_edge) else $error("out moved");
    property p_word_len; $rose(latch_strobe) |-> rises_q == 8'd20;
    endproperty
    a_word_len: assert property (p_word_len) else $error("word len");
    property p_clk_high; $rose(serial_clk) |-> ##25 $fell(serial_clk);
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("clk high");
    property p_strobe_len; $rose(latch_strobe) |-> ##15 $fell(latch_strobe);
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe");
    property p_strobe_clk; latch_strobe |-> !serial_clk; endproperty
    a_strobe_clk: assert property (p_strobe_clk) else $error("clk");
    property p_data_stable; serial_clk |-> $stable(serial_in); endproperty
    a_data_stable: assert property (p_data_stable) else $error("data");

    cover property ($fell(latch_strobe));
    cover property ($rose(blank_in));
    cover property (latch_strobe && blank_in);
endmodule : vsl_link_assertions

// *** verilog/vsl_ctrl.sv ***
/*
 Controller end: takes 20-bit words from a FIFO and sends each
 MSB first, then pulses the latch strobe.
 Assumes the driver end samples the link with its own clock.
*/
`timescale 1ns/1ps
module vsl_ctrl import vsl_pkg::*; #(
    parameter int WIDTH = WORD_BITS_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Word input
    input  wire logic             word_valid,
    output logic                  word_ready,
    input  wire logic [WIDTH-1:0] word_bits,
    // Display control
    input  wire logic             blank_req,
    output logic                  busy,
    // Link
    vsl_link_if.ctrl              link
);
    logic             f_valid;
    logic             f_ready;
    logic [WIDTH-1:0] f_data;
    vsl_state_type    st_q;
    logic [WIDTH-1:0] sh_q;
    logic [4:0]       bit_q;
    logic [7:0]       tmr_q;
    logic             sclk_q;
    logic             sdat_q;
    logic             strb_q;
    logic             blank_q;

    vsl_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) i_vsl_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (word_valid),
        .in_ready  (word_ready),
        .in_data   (word_bits),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign f_ready = (st_q == VSL_IDLE);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q    <= VSL_IDLE;
            sh_q    <= '0;
            bit_q   <= 5'h00;
            tmr_q   <= 8'h00;
            sclk_q  <= 1'b0;
            sdat_q  <= 1'b0;
            strb_q  <= 1'b0;
            blank_q <= 1'b0;
            busy    <= 1'b0;
        end else begin
            blank_q <= blank_req;
            busy    <= (st_q != VSL_IDLE) || f_valid;
            case (st_q)
                VSL_IDLE: begin
                    sclk_q <= 1'b0;
                    if (f_valid) begin
                        sh_q   <= f_data << 1;
                        sdat_q <= f_data[WIDTH-1];
                        bit_q  <= 5'(WIDTH - 1);
                        tmr_q  <= 8'(SCLK_HALF_CYC - 1);
                        st_q   <= VSL_LOW;
                    end
                end
                VSL_LOW: begin
                    if (tmr_q == 8'h00) begin
                        sclk_q <= 1'b1;
                        tmr_q  <= 8'(SCLK_HALF_CYC - 1);
                        st_q   <= VSL_HIGH;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                VSL_HIGH: begin
                    if (tmr_q == 8'h00) begin
                        sclk_q <= 1'b0;
                        tmr_q  <= 8'(SCLK_HALF_CYC - 1);
                        if (bit_q == 5'h00) begin
                            st_q <= VSL_STRB;
                        end else begin
                            sdat_q <= sh_q[WIDTH-1];
                            sh_q   <= sh_q << 1;
                            bit_q  <= bit_q - 5'h01;
                            st_q   <= VSL_LOW;
                        end
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                VSL_STRB: begin
                    if (tmr_q == 8'h00) begin
                        strb_q <= 1'b1;
                        tmr_q  <= 8'(STROBE_HIGH_CYC - 1);
                        st_q   <= VSL_STRB_L;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                VSL_STRB_L: begin
                    if (tmr_q == 8'h00) begin
                        strb_q <= 1'b0;
                        st_q   <= VSL_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                default: begin
                    st_q <= VSL_IDLE;
                end
            endcase
        end
    end

    // Dedicated strobe per driver; one driver per controller here
    assign link.serial_clk   = sclk_q;
    assign link.serial_in    = sdat_q;
    assign link.latch_strobe = strb_q;
    assign link.blank_in     = blank_q;
endmodule : vsl_ctrl

// *** verilog/vsl_driver.sv ***
/*
 Display driver end: 20-bit shift register, transparent output latch,
 blanking gate and cascade output.
 Assumes link pins are asynchronous to clk and are synchronised here.
*/
`timescale 1ns/1ps

module vsl_driver import vsl_pkg::*; #(
    parameter int WIDTH = WORD_BITS_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Link
    vsl_link_if.drv               link,
    // Display outputs
    output logic [WIDTH-1:0]      drive_out,
    output logic [WIDTH-1:0]      latch_view
);
    logic [2:0]       sclk_sync_q;
    logic [1:0]       din_sync_q;
    logic [1:0]       strb_sync_q;
    logic [1:0]       blank_sync_q;
    logic [WIDTH-1:0] shift_q;
    logic [WIDTH-1:0] latch_q;
    logic             sout_q;
    logic             rise;

    // Two-stage synchronisers; third stage only for edge detection
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclk_sync_q  <= 3'h0;
            din_sync_q   <= 2'h0;
            strb_sync_q  <= 2'h0;
            blank_sync_q <= 2'h0;
        end else begin
            sclk_sync_q  <= {sclk_sync_q[1:0], link.serial_clk};
            din_sync_q   <= {din_sync_q[0], link.serial_in};
            strb_sync_q  <= {strb_sync_q[0], link.latch_strobe};
            blank_sync_q <= {blank_sync_q[0], link.blank_in};
        end
    end

    assign rise = sclk_sync_q[1] && !sclk_sync_q[2];

    // Shift register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift_q <= SHIFT_RESET;
        end else if (rise) begin
            shift_q <= {shift_q[WIDTH-2:0], din_sync_q[1]};
        end
    end

    // Transparent latch, frozen while strobe low
    always_ff @(posedge clk) begin
        if (!resetn) begin
            latch_q <= LATCH_RESET;
        end else if (strb_sync_q[1]) begin
            latch_q <= shift_q;
        end
    end
    // Last copy before strobe seen low is the captured word

    // Outputs from flip-flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_out  <= '0;
            sout_q     <= 1'b0;
            latch_view <= '0;
        end else begin
            sout_q     <= shift_q[WIDTH-1];
            latch_view <= latch_q;
            if (blank_sync_q[1]) begin
                drive_out <= '0;
            end else begin
                drive_out <= latch_q;
            end
        end
    end

    assign link.serial_out = sout_q;
endmodule : vsl_driver

// *** verilog/vsl_fifo.sv ***
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module vsl_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : vsl_fifo
